// >>> hdl/lppcb_pkg.sv
// Package of offsets, field positions and reset values of the low-power pad configuration bank.
`default_nettype none
package lppcb_pkg;
	typedef logic [31:0] lppcb_word_t;
	localparam int          ADDR_W     = 8;
	localparam int          NUM_WORDS  = 17;
	localparam int          NUM_TOUCH  = 10;
	localparam int          NUM_LPPAD  = 18;
	localparam int          NUM_PAD    = 3;
	// Byte offsets on the register port.
	localparam logic [7:0]  OFS_DAC2   = 8'h88;
	localparam logic [7:0]  OFS_XTAL   = 8'h8C;
	localparam logic [7:0]  OFS_TCFG   = 8'h90;
	localparam logic [7:0]  OFS_TPAD0  = 8'h94;
	localparam logic [7:0]  OFS_WAKE   = 8'hBC;
	localparam logic [7:0]  OFS_XPDSRC = 8'hC0;
	localparam logic [7:0]  OFS_TWSEL  = 8'hC4;
	localparam logic [7:0]  OFS_XINV   = 8'hC8;
	// Word indices, counted from the second DAC pad register.
	localparam logic [4:0]  IDX_DAC2   = 5'h00;
	localparam logic [4:0]  IDX_XTAL   = 5'h01;
	localparam logic [4:0]  IDX_TCFG   = 5'h02;
	localparam logic [4:0]  IDX_TPAD0  = 5'h03;
	localparam logic [4:0]  IDX_WAKE   = 5'h0D;
	localparam logic [4:0]  IDX_XPDSRC = 5'h0E;
	localparam logic [4:0]  IDX_TWSEL  = 5'h0F;
	localparam logic [4:0]  IDX_XINV   = 5'h10;
	localparam logic [4:0]  IDX_NONE   = 5'h1F;
	// Second DAC pad word.
	localparam int          B_DAC_VAL  = 19;
	localparam int          B_DAC_XPD  = 18;
	localparam int          B_DAC_FRC  = 11;
	// Per-pad field positions: pad 0 second DAC pad, 1 crystal_neg_pad, 2 crystal_pos_pad.
	localparam logic [4:0]  PAD_IDX    [NUM_PAD] = '{IDX_DAC2, IDX_XTAL, IDX_XTAL};
	localparam int          PAD_DRV_B  [NUM_PAD] = '{30, 30, 25};
	localparam int          PAD_HOLD_B [NUM_PAD] = '{29, 29, 24};
	localparam int          PAD_PD_B   [NUM_PAD] = '{28, 28, 23};
	localparam int          PAD_PU_B   [NUM_PAD] = '{27, 27, 22};
	localparam int          PAD_RTE_B  [NUM_PAD] = '{17, 18, 17};
	localparam int          PAD_FUN_B  [NUM_PAD] = '{16, 16, 11};
	localparam int          PAD_SSEL_B [NUM_PAD] = '{15, 15, 10};
	localparam int          PAD_SIE_B  [NUM_PAD] = '{14, 14, 9};
	localparam int          PAD_SOE_B  [NUM_PAD] = '{13, 13, 8};
	localparam int          PAD_NIE_B  [NUM_PAD] = '{12, 12, 7};
	// Crystal word extras.
	localparam int          B_XTAL_XPD = 19;
	// Touch words.
	localparam int          B_TCH_BIAS = 31;
	localparam int          B_TCH_SLP  = 20;
	localparam int          B_TCH_STRT = 19;
	localparam int          B_TCH_TIE  = 18;
	localparam int          B_TCH_XPD  = 17;
	// Select words.
	localparam int          B_SEL      = 27;
	localparam int          B_TW_SCL   = 31;
	localparam int          B_TW_SDA   = 30;
	localparam int          B_XINV     = 30;
	localparam logic [3:0]  TW_SDA_PAD0 = 4'h1;
	localparam logic [3:0]  TW_SDA_PAD1 = 4'h3;
	localparam logic [3:0]  TW_SCL_PAD0 = 4'h0;
	localparam logic [3:0]  TW_SCL_PAD1 = 4'h2;
	// Writable-bit masks; other bits are reserved and read zero.
	localparam lppcb_word_t MASK_DAC2  = 32'hFFFF_F800;
	localparam lppcb_word_t MASK_XTAL  = 32'hFFFF_FFF8;
	localparam lppcb_word_t MASK_TCFG  = 32'hFFC0_0000;
	localparam lppcb_word_t MASK_TPAD  = 32'h007F_0000;
	localparam lppcb_word_t MASK_SEL   = 32'hF800_0000;
	localparam lppcb_word_t MASK_TW    = 32'hC000_0000;
	localparam lppcb_word_t MASK_XINV  = 32'h4000_0000;
	// Reset values.
	localparam lppcb_word_t RST_XTAL   = 32'h8400_0000;
	localparam lppcb_word_t RST_TPAD   = 32'h0040_0000;
	localparam lppcb_word_t RST_ZERO   = 32'h0000_0000;
	localparam logic [2:0]  SLOPE_RST  = 3'h4;
endpackage : lppcb_pkg
`default_nettype wire

// >>> hdl/lppcb_sync.sv
// Three-stage synchroniser that passes a change once the second and third stages agree.
`default_nettype none
module lppcb_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,     // System clock.
	input  wire logic         nrst,     // Asynchronous reset, active low.
	input  wire logic [W-1:0] asyncIn,  // Pin levels from outside the clock domain.
	output logic      [W-1:0] syncOut   // Filtered, synchronised levels.
);
	logic [W-1:0] stage1_reg, stage1_next;
	logic [W-1:0] stage2_reg, stage2_next;
	logic [W-1:0] stage3_reg, stage3_next;
	logic [W-1:0] out_reg,    out_next;

	always_comb
	begin
		stage1_next = asyncIn;
		stage2_next = stage1_reg;
		stage3_next = stage2_reg;
		// A single-cycle disagreement is a glitch and must not reach the pad logic.
		out_next    = (stage2_reg & stage3_reg) | (out_reg & (stage2_reg | stage3_reg));
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
			out_reg    <= '0;
		end
		else
		begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
			stage3_reg <= stage3_next;
			out_reg    <= out_next;
		end
	end

	assign syncOut = out_reg;
endmodule : lppcb_sync
`default_nettype wire

// >>> hdl/lppcb_bank.sv
// Configuration register bank for the low-power-domain pads.
//
// Implementation choice: the plain strobed port.
`default_nettype none
// How it works
// - Second DAC pad route bit: 0 digital pin multiplexer, 1 low-power block.
// - Second DAC pad function bit chooses low-power function 0 or 1.
// - Sleep-select 1 makes the pad use its sleep-mode enables.
// - Each pad has sleep input, sleep output and normal input enables; 1 enables.
// - Hold bit 1 freezes the pad output value; 0 lets it follow.
// - Crystal pad pull-down and pull-up bits enable the pull when 1.
// - Each crystal pad routes to the multiplexer at 0, low-power block at 1.
// - Each touch pad has a 3-bit slope field resetting to binary 100.
// - Touch pad tie bit ties low at 0, high at 1.
// - Touch bias power bit powers the sensor bias when 1.
// - Wake select field picks which of low-power pads 0 to 17 wakes.
// - Crystal power-down enable is selected pad level XOR invert bit 30.
// - Two-wire data line uses touch pad 1 at 0, touch pad 3 at 1.
// - Two-wire clock line uses touch pad 0 at 0, touch pad 2 at 1.
module lppcb_bank
	import lppcb_pkg::*;
(
	input  wire logic                 mclk,            // System clock, 40 MHz.
	input  wire logic                 nrst,            // Asynchronous reset, active low.
	input  wire logic [ADDR_W-1:0]    regAddr,         // Register byte address.
	input  wire logic [31:0]          regWrData,       // Register write data.
	input  wire logic                 regWrEn,         // Write strobe.
	input  wire logic                 regRdEn,         // Read strobe.
	output logic      [31:0]          regRdData,       // Read data, one cycle after the strobe.
	input  wire logic [NUM_PAD-1:0]   padLiveOut,      // Functional output value per pad.
	input  wire logic [NUM_PAD-1:0]   padFuncOutEn,    // Normal-mode output enable per pad.
	output logic      [NUM_PAD-1:0]   padRouteLp,      // 1 routes the pad to the low-power block.
	output logic      [NUM_PAD-1:0]   padFuncSel,      // Low-power function choice.
	output logic      [NUM_PAD-1:0]   padInEn,         // Effective input enable.
	output logic      [NUM_PAD-1:0]   padOutEn,        // Effective output enable.
	output logic      [NUM_PAD-1:0]   padPullDown,     // Pull-down enable.
	output logic      [NUM_PAD-1:0]   padPullUp,       // Pull-up enable.
	output logic      [2*NUM_PAD-1:0] padDrive,        // Drive strength, two bits per pad.
	output logic      [NUM_PAD-1:0]   padOutValue,     // Output value, frozen while on hold.
	output logic      [7:0]           dacValue,        // Second DAC pad DAC code, frozen on hold.
	output logic                      dacPowerOn,      // Second DAC pad DAC power.
	output logic                      xtalPowerOn,     // 32 kHz crystal oscillator power.
	output logic                      touchBiasPower,  // Touch sensor bias power.
	output logic      [3*NUM_TOUCH-1:0] touchSlope,    // Slope control, three bits per pad.
	output logic      [NUM_TOUCH-1:0] touchTieHigh,    // Default tie level per pad.
	output logic      [NUM_TOUCH-1:0] touchPowerOn,    // Touch pad power per pad.
	output logic      [NUM_TOUCH-1:0] touchStart,      // Touch measurement start per pad.
	input  wire logic [NUM_LPPAD-1:0] lpPadIn,         // Low-power pad levels from the pins.
	output logic                      wakeLevel,       // Level of the selected wake-up pad.
	output logic                      crystalPdEnable, // Crystal power-down enable.
	output logic      [3:0]           lpBusDataPad,    // Touch pad used for two-wire data.
	output logic      [3:0]           lpBusClockPad    // Touch pad used for two-wire clock.
);
	lppcb_word_t            regFile_reg [NUM_WORDS];
	lppcb_word_t            regFile_next[NUM_WORDS];
	logic [31:0]            rdData_reg, rdData_next;
	logic [NUM_PAD-1:0]     padOut_reg, padOut_next;
	logic [7:0]             dacHeld_reg, dacHeld_next;
	logic                   wake_reg, wake_next;
	logic                   xpd_reg, xpd_next;
	logic [NUM_LPPAD-1:0]   lpPadSync;
	logic [4:0]             wrIdx;
	logic [4:0]             rdIdx;

	// Decodes a byte address into a word index, or IDX_NONE when unmapped.
	function automatic logic [4:0] wordIndex(input logic [ADDR_W-1:0] addr);
		logic [7:0] diff;
		diff = addr - OFS_DAC2;
		if (addr[1:0] != 2'h0)
			return IDX_NONE;
		else if (addr < OFS_DAC2)
			return IDX_NONE;
		else if (addr > OFS_XINV)
			return IDX_NONE;
		else
			return diff[6:2];
	endfunction : wordIndex

	function automatic lppcb_word_t wordMask(input logic [4:0] idx);
		if (idx == IDX_DAC2)
			return MASK_DAC2;
		else if (idx == IDX_XTAL)
			return MASK_XTAL;
		else if (idx == IDX_TCFG)
			return MASK_TCFG;
		else if (idx == IDX_WAKE || idx == IDX_XPDSRC)
			return MASK_SEL;
		else if (idx == IDX_TWSEL)
			return MASK_TW;
		else if (idx == IDX_XINV)
			return MASK_XINV;
		else
			return MASK_TPAD;
	endfunction : wordMask

	function automatic lppcb_word_t wordReset(input logic [4:0] idx);
		if (idx == IDX_XTAL)
			return RST_XTAL;
		else if (idx >= IDX_TPAD0 && idx < IDX_WAKE)
			return RST_TPAD;
		else
			return RST_ZERO;
	endfunction : wordReset

	// Selector value k picks low-power pad k; values past the last pad read low.
	function automatic logic padPick(input logic [NUM_LPPAD-1:0] pads, input logic [4:0] sel);
		if (sel < 5'(NUM_LPPAD))
			return pads[sel];
		else
			return 1'b0;
	endfunction : padPick

	lppcb_sync #(
		.W       (NUM_LPPAD)
	) u_padSync (
		.mclk    (mclk),
		.nrst    (nrst),
		.asyncIn (lpPadIn),
		.syncOut (lpPadSync)
	);

	assign wrIdx = wordIndex(regAddr);
	assign rdIdx = wordIndex(regAddr);

	always_comb
	begin
		for (int i = 0; i < NUM_WORDS; i++)
		begin
			regFile_next[i] = regFile_reg[i];
			if (regWrEn && wrIdx == 5'(i))
				regFile_next[i] = regWrData & wordMask(5'(i));
		end
		rdData_next = 32'h0000_0000;
		if (regRdEn && rdIdx != IDX_NONE)
			rdData_next = regFile_reg[rdIdx];
	end

	always_comb
	begin
		for (int p = 0; p < NUM_PAD; p++)
		begin
			// A held pad keeps the value it had when hold was set.
			if (regFile_reg[PAD_IDX[p]][PAD_HOLD_B[p]])
				padOut_next[p] = padOut_reg[p];
			else
				padOut_next[p] = padLiveOut[p];
		end
		if (regFile_reg[IDX_DAC2][PAD_HOLD_B[0]])
			dacHeld_next = dacHeld_reg;
		else
			dacHeld_next = regFile_reg[IDX_DAC2][B_DAC_VAL +: 8];
		wake_next = padPick(lpPadSync, regFile_reg[IDX_WAKE][B_SEL +: 5]);
		xpd_next  = padPick(lpPadSync, regFile_reg[IDX_XPDSRC][B_SEL +: 5])
			^ regFile_reg[IDX_XINV][B_XINV];
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < NUM_WORDS; i++)
				regFile_reg[i] <= wordReset(5'(i));
			rdData_reg  <= 32'h0000_0000;
			padOut_reg  <= '0;
			dacHeld_reg <= 8'h00;
			wake_reg    <= 1'b0;
			xpd_reg     <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < NUM_WORDS; i++)
				regFile_reg[i] <= regFile_next[i];
			rdData_reg  <= rdData_next;
			padOut_reg  <= padOut_next;
			dacHeld_reg <= dacHeld_next;
			wake_reg    <= wake_next;
			xpd_reg     <= xpd_next;
		end
	end

	// Pad controls. Powering the DAC does not force the pad off; software tristates it first.
	always_comb
	begin
		for (int p = 0; p < NUM_PAD; p++)
		begin
			padRouteLp[p]    = regFile_reg[PAD_IDX[p]][PAD_RTE_B[p]];
			padFuncSel[p]    = regFile_reg[PAD_IDX[p]][PAD_FUN_B[p]];
			padPullDown[p]   = regFile_reg[PAD_IDX[p]][PAD_PD_B[p]];
			padPullUp[p]     = regFile_reg[PAD_IDX[p]][PAD_PU_B[p]];
			padDrive[2*p +: 2] = regFile_reg[PAD_IDX[p]][PAD_DRV_B[p] +: 2];
			if (regFile_reg[PAD_IDX[p]][PAD_SSEL_B[p]])
			begin
				padInEn[p]  = regFile_reg[PAD_IDX[p]][PAD_SIE_B[p]];
				padOutEn[p] = regFile_reg[PAD_IDX[p]][PAD_SOE_B[p]];
			end
			else
			begin
				padInEn[p]  = regFile_reg[PAD_IDX[p]][PAD_NIE_B[p]];
				padOutEn[p] = padFuncOutEn[p];
			end
		end
		for (int t = 0; t < NUM_TOUCH; t++)
		begin
			touchSlope[3*t +: 3] = regFile_reg[IDX_TPAD0 + 5'(t)][B_TCH_SLP +: 3];
			touchTieHigh[t]      = regFile_reg[IDX_TPAD0 + 5'(t)][B_TCH_TIE];
			touchPowerOn[t]      = regFile_reg[IDX_TPAD0 + 5'(t)][B_TCH_XPD];
			touchStart[t]        = regFile_reg[IDX_TPAD0 + 5'(t)][B_TCH_STRT];
		end
	end

	assign padOutValue    = padOut_reg;
	assign dacValue       = dacHeld_reg;
	assign dacPowerOn     = regFile_reg[IDX_DAC2][B_DAC_XPD] | regFile_reg[IDX_DAC2][B_DAC_FRC];
	assign xtalPowerOn    = regFile_reg[IDX_XTAL][B_XTAL_XPD];
	assign touchBiasPower = regFile_reg[IDX_TCFG][B_TCH_BIAS];
	assign wakeLevel      = wake_reg;
	assign crystalPdEnable = xpd_reg;
	assign regRdData      = rdData_reg;
	assign lpBusDataPad   = regFile_reg[IDX_TWSEL][B_TW_SDA] ? TW_SDA_PAD1 : TW_SDA_PAD0;
	assign lpBusClockPad  = regFile_reg[IDX_TWSEL][B_TW_SCL] ? TW_SCL_PAD1 : TW_SCL_PAD0;

	// Checks on the bank's own behaviour.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	AST_DAC2_ROUTE: assert property (
		regWrEn && regAddr == OFS_DAC2 |=> padRouteLp[0] == $past(regWrData[PAD_RTE_B[0]]))
		else $error("Second DAC pad route does not follow the written bit.");
	AST_DAC2_FUNC: assert property (
		regWrEn && regAddr == OFS_DAC2 |=> padFuncSel[0] == $past(regWrData[PAD_FUN_B[0]]))
		else $error("Second DAC pad function does not follow the written bit.");
	AST_SLEEP_ENABLES: assert property (
		regWrEn && regAddr == OFS_DAC2 && regWrData[PAD_SSEL_B[0]]
		|=> padInEn[0] == $past(regWrData[PAD_SIE_B[0]])
		&& padOutEn[0] == $past(regWrData[PAD_SOE_B[0]]))
		else $error("Sleep configuration does not use the sleep enables.");
	AST_NORMAL_ENABLES: assert property (
		regWrEn && regAddr == OFS_DAC2 && !regWrData[PAD_SSEL_B[0]]
		|=> padInEn[0] == $past(regWrData[PAD_NIE_B[0]]) && padOutEn[0] == padFuncOutEn[0])
		else $error("Normal configuration does not use the normal enables.");
	AST_HOLD_FREEZE: assert property (
		regFile_reg[IDX_XTAL][PAD_HOLD_B[2]] |=> $stable(padOutValue[2]))
		else $error("Held crystal pad output changed.");
	AST_HOLD_DAC: assert property (
		regFile_reg[IDX_DAC2][PAD_HOLD_B[0]] |=> $stable(dacValue))
		else $error("Held DAC value changed.");
	AST_RELEASE_FOLLOW: assert property (
		!regFile_reg[IDX_XTAL][PAD_HOLD_B[1]] |=> padOutValue[1] == $past(padLiveOut[1]))
		else $error("Released crystal pad does not follow its live value.");
	AST_XTAL_PULL: assert property (
		regWrEn && regAddr == OFS_XTAL
		|=> padPullUp[2] == $past(regWrData[PAD_PU_B[2]])
		&& padPullDown[1] == $past(regWrData[PAD_PD_B[1]]))
		else $error("Crystal pad pulls do not follow the written bits.");
	AST_XTAL_ROUTE: assert property (
		regWrEn && regAddr == OFS_XTAL
		|=> padRouteLp[1] == $past(regWrData[PAD_RTE_B[1]])
		&& padRouteLp[2] == $past(regWrData[PAD_RTE_B[2]]))
		else $error("Crystal pad routes do not follow the written bits.");
	AST_SLOPE_RESET: assert property (
		$rose(nrst) |-> touchSlope[2:0] == SLOPE_RST && touchSlope[29:27] == SLOPE_RST)
		else $error("Touch slope field did not reset to binary 100.");
	AST_TIE_LEVEL: assert property (
		regWrEn && regAddr == OFS_TPAD0 |=> touchTieHigh[0] == $past(regWrData[B_TCH_TIE]))
		else $error("Touch tie level does not follow the written bit.");
	AST_BIAS_POWER: assert property (
		regWrEn && regAddr == OFS_TCFG |=> touchBiasPower == $past(regWrData[B_TCH_BIAS]))
		else $error("Touch bias power does not follow the written bit.");
	AST_WAKE_PICK: assert property (
		regFile_reg[IDX_WAKE][B_SEL +: 5] == 5'h11 |=> wakeLevel == $past(lpPadSync[17]))
		else $error("Wake level is not the selected pad.");
	AST_XPD_XOR: assert property (
		regFile_reg[IDX_XPDSRC][B_SEL +: 5] == 5'h11 && !regFile_reg[IDX_XINV][B_XINV]
		|=> crystalPdEnable == $past(lpPadSync[17]))
		else $error("Crystal power-down enable is not the pad level.");
	AST_XPD_INVERT: assert property (
		regFile_reg[IDX_XPDSRC][B_SEL +: 5] == 5'h11 && regFile_reg[IDX_XINV][B_XINV]
		|=> crystalPdEnable == !$past(lpPadSync[17]))
		else $error("Crystal power-down enable is not inverted.");
	AST_BUS_PADS: assert property (
		regWrEn && regAddr == OFS_TWSEL
		|=> lpBusDataPad == ($past(regWrData[B_TW_SDA]) ? 4'h3 : 4'h1)
		&& lpBusClockPad == ($past(regWrData[B_TW_SCL]) ? 4'h2 : 4'h0))
		else $error("Two-wire bus pads do not follow the select bits.");
	AST_READBACK: assert property (
		regWrEn && regAddr == OFS_WAKE ##1 regRdEn && regAddr == OFS_WAKE && !regWrEn
		|=> regRdData == ($past(regWrData, 2) & MASK_SEL))
		else $error("Read did not return the stored value.");
	AST_READ_ONE_CYCLE: assert property (
		!regRdEn |=> regRdData == 32'h0000_0000)
		else $error("Read data stood outside its cycle.");

	COV_SLEEP_PAD: cover property (
		regWrEn && regAddr == OFS_DAC2 && regWrData[PAD_SSEL_B[0]] ##1 padOutEn[0]);
	COV_HOLD: cover property (
		regFile_reg[IDX_DAC2][PAD_HOLD_B[0]] && padLiveOut[0] != padOutValue[0]);
	COV_WAKE: cover property ($rose(wakeLevel));
	COV_TOUCH_READ: cover property (regRdEn && regAddr == OFS_TPAD0);
endmodule : lppcb_bank
`default_nettype wire

// >>> testbench/lppcb_pad_model.sv
// Model of the pads and analog parts that sit on the far side of the pad configuration bank.
`default_nettype none
module lppcb_pad_model
	import lppcb_pkg::*;
(
	input  wire logic                 mclk,          // System clock.
	input  wire logic                 nrst,          // Asynchronous reset, active low.
	input  wire logic [NUM_LPPAD-1:0] pinReq,        // Pin levels that the bench asks for.
	input  wire logic [NUM_PAD-1:0]   liveReq,       // Live output values asked for.
	input  wire logic [NUM_PAD-1:0]   oeReq,         // Normal output enables asked for.
	input  wire logic                 dacPowerOn,    // DAC power from the bank.
	input  wire logic [NUM_PAD-1:0]   padInEn,       // Effective input enables.
	input  wire logic [NUM_PAD-1:0]   padOutEn,      // Effective output enables.
	input  wire logic [NUM_PAD-1:0]   padPullDown,   // Pull-down enables.
	input  wire logic [NUM_PAD-1:0]   padPullUp,     // Pull-up enables.
	output logic      [NUM_LPPAD-1:0] lpPadIn,       // Pin levels toward the bank.
	output logic      [NUM_PAD-1:0]   padLiveOut,    // Live output values toward the bank.
	output logic      [NUM_PAD-1:0]   padFuncOutEn,  // Normal output enables toward the bank.
	output logic                      tristateFault  // Set once the DAC ran with a buffer or pull of its pad enabled.
);
	timeunit 1ns;
	timeprecision 100ps;
	assign padLiveOut   = liveReq;
	assign padFuncOutEn = oeReq;
	initial lpPadIn = '0;
	initial tristateFault = 1'b0;
	// Pins are asynchronous, so levels land off the clock phase to exercise the synchroniser.
	always @(pinReq) lpPadIn <= #7 pinReq;
	// A powered DAC fights any buffer or pull left on its pad, so flag that case.
	always @(posedge mclk)
	begin
		if (nrst && dacPowerOn && (padInEn[0] || padOutEn[0] || padPullDown[0] || padPullUp[0]))
			tristateFault <= 1'b1;
	end
endmodule : lppcb_pad_model
`default_nettype wire

// >>> testbench/lppcb_bank_test.sv
// Self-checking bench for the low-power pad configuration bank.
`default_nettype none
module lppcb_bank_test
	import lppcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                   mclk, nrst, regWrEn, regRdEn, dacPowerOn, xtalPowerOn;
	logic                   touchBiasPower, wakeLevel, crystalPdEnable, tristateFault;
	logic [ADDR_W-1:0]      regAddr;
	logic [31:0]            regWrData, regRdData;
	logic [NUM_PAD-1:0]     liveReq, oeReq, padLiveOut, padFuncOutEn, padRouteLp, padFuncSel;
	logic [NUM_PAD-1:0]     padInEn, padOutEn, padPullDown, padPullUp, padOutValue;
	logic [2*NUM_PAD-1:0]   padDrive;
	logic [7:0]             dacValue;
	logic [3*NUM_TOUCH-1:0] touchSlope;
	logic [NUM_TOUCH-1:0]   touchTieHigh, touchPowerOn, touchStart;
	logic [NUM_LPPAD-1:0]   pinReq, lpPadIn;
	logic [3:0]             lpBusDataPad, lpBusClockPad;
	int                     mismatches, numChecks;

	lppcb_bank i_dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .padLiveOut(padLiveOut),
		.padFuncOutEn(padFuncOutEn), .padRouteLp(padRouteLp), .padFuncSel(padFuncSel),
		.padInEn(padInEn), .padOutEn(padOutEn), .padPullDown(padPullDown),
		.padPullUp(padPullUp), .padDrive(padDrive), .padOutValue(padOutValue),
		.dacValue(dacValue), .dacPowerOn(dacPowerOn), .xtalPowerOn(xtalPowerOn),
		.touchBiasPower(touchBiasPower), .touchSlope(touchSlope), .touchTieHigh(touchTieHigh),
		.touchPowerOn(touchPowerOn), .touchStart(touchStart), .lpPadIn(lpPadIn),
		.wakeLevel(wakeLevel), .crystalPdEnable(crystalPdEnable),
		.lpBusDataPad(lpBusDataPad), .lpBusClockPad(lpBusClockPad));

	lppcb_pad_model i_pads (.mclk(mclk), .nrst(nrst), .pinReq(pinReq), .liveReq(liveReq),
		.oeReq(oeReq), .dacPowerOn(dacPowerOn), .padInEn(padInEn), .padOutEn(padOutEn),
		.padPullDown(padPullDown), .padPullUp(padPullUp), .lpPadIn(lpPadIn),
		.padLiveOut(padLiveOut), .padFuncOutEn(padFuncOutEn), .tristateFault(tristateFault));

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	function automatic lppcb_word_t bitAt(input int b);
		return 32'h1 << b;
	endfunction : bitAt

	task automatic chk(input lppcb_word_t seen, input lppcb_word_t exp);
		numChecks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input lppcb_word_t d);
		@(posedge mclk);
		regWrEn   <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge mclk);
		regWrEn <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input lppcb_word_t exp);
		@(posedge mclk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRdEn <= 1'b0;
		#1;
		chk(regRdData, exp);
	endtask : rd

	// Write followed at once by a read of the same word, with no idle cycle between.
	task automatic wr_rd(input logic [7:0] a, input lppcb_word_t d, input lppcb_word_t exp);
		@(posedge mclk);
		regWrEn   <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge mclk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b1;
		@(posedge mclk);
		regRdEn <= 1'b0;
		#1;
		chk(regRdData, exp);
	endtask : wr_rd

	task automatic end_of_test;
		$display("Checks made %0d, mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (6000) @(posedge mclk);
		mismatches++;
		end_of_test();
	end

	initial
	begin
		nrst = 1'b0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		liveReq = 3'h0;
		oeReq = 3'h1;
		pinReq = 18'h0;
		mismatches = 0;
		numChecks = 0;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		cyc(1);
		chk(32'(touchSlope), 32'({NUM_TOUCH{SLOPE_RST}}));
		chk(32'(padDrive), 32'h28);
		rd(OFS_XTAL, RST_XTAL);
		rd(OFS_TPAD0 + 8'h24, RST_TPAD);
		rd(8'h84, 32'h0);
		rd(OFS_XTAL + 8'h1, 32'h0);
		wr(OFS_DAC2, bitAt(PAD_RTE_B[0]) | bitAt(PAD_FUN_B[0]) | 32'h0528_0000);
		chk(32'(padRouteLp[0]), 32'h1);
		chk(32'(padFuncSel[0]), 32'h1);
		cyc(2);
		chk(32'(dacValue), 32'hA5);
		rd(OFS_DAC2, bitAt(17) | bitAt(16) | 32'h0528_0000);
		wr(OFS_DAC2, bitAt(PAD_SSEL_B[0]) | bitAt(PAD_SIE_B[0]) | bitAt(PAD_SOE_B[0]));
		oeReq <= 3'h0;
		cyc(1);
		chk(32'(padRouteLp[0]), 32'h0);
		chk(32'(padFuncSel[0]), 32'h0);
		chk(32'({padInEn[0], padOutEn[0]}), 32'h3);
		wr(OFS_DAC2, bitAt(PAD_SIE_B[0]) | bitAt(PAD_SOE_B[0]));
		chk(32'({padInEn[0], padOutEn[0]}), 32'h0);
		oeReq <= 3'h1;
		wr(OFS_DAC2, bitAt(PAD_NIE_B[0]));
		chk(32'({padInEn[0], padOutEn[0]}), 32'h3);
		// The DAC goes on only with every buffer and pull of its pad off.
		oeReq <= 3'h0;
		wr(OFS_DAC2, bitAt(PAD_SSEL_B[0]) | bitAt(B_DAC_XPD));
		chk(32'({dacPowerOn, padInEn[0], padOutEn[0]}), 32'h4);
		liveReq <= 3'h7;
		cyc(2);
		chk(32'(padOutValue), 32'h7);
		wr(OFS_DAC2, bitAt(PAD_HOLD_B[0]) | 32'h02D0_0000);
		liveReq <= 3'h0;
		cyc(3);
		chk(32'({dacValue, padOutValue}), 32'h001);
		wr(OFS_DAC2, 32'h0);
		cyc(2);
		chk(32'({dacValue, padOutValue}), 32'h0);
		wr(OFS_XTAL, bitAt(PAD_PD_B[1]) | bitAt(PAD_PU_B[2]) | bitAt(PAD_RTE_B[1]) | 32'h7);
		chk(32'({padPullDown[2:1], padPullUp[2:1]}), 32'h6);
		chk(32'(padRouteLp[2:1]), 32'h1);
		rd(OFS_XTAL, bitAt(PAD_PD_B[1]) | bitAt(PAD_PU_B[2]) | bitAt(PAD_RTE_B[1]));
		wr(OFS_XTAL, bitAt(PAD_PU_B[1]) | bitAt(PAD_PD_B[2]) | bitAt(PAD_RTE_B[2]));
		chk(32'({padPullDown[2:1], padPullUp[2:1]}), 32'h9);
		chk(32'(padRouteLp[2:1]), 32'h2);
		// Pad 2 freezes at the value it had when hold went on; pads 0 and 1 keep following.
		liveReq <= 3'h4;
		cyc(2);
		wr(OFS_XTAL, bitAt(PAD_HOLD_B[2]) | bitAt(B_XTAL_XPD));
		chk(32'(xtalPowerOn), 32'h1);
		liveReq <= 3'h2;
		cyc(2);
		chk(32'(padOutValue), 32'h6);
		wr(OFS_TPAD0 + 8'h24, 32'h0026_0000);
		chk(32'({touchSlope[29:27], touchTieHigh[9], touchPowerOn[9]}), 32'hB);
		chk(32'({touchSlope[2:0], touchTieHigh[0]}), 32'h8);
		wr(OFS_TPAD0, bitAt(B_TCH_TIE) | bitAt(B_TCH_STRT));
		chk(32'({touchStart[0], touchTieHigh[0], touchSlope[2:0]}), 32'h18);
		wr(OFS_TCFG, bitAt(B_TCH_BIAS));
		chk(32'(touchBiasPower), 32'h1);
		wr(OFS_TCFG, 32'h0);
		chk(32'(touchBiasPower), 32'h0);
		pinReq <= 18'h20000;
		wr_rd(OFS_WAKE, (32'(17) << B_SEL) | 32'h0000_00FF, 32'(17) << B_SEL);
		wr(OFS_XPDSRC, 32'(17) << B_SEL);
		wr(OFS_XINV, bitAt(B_XINV));
		cyc(8);
		chk(32'({wakeLevel, crystalPdEnable}), 32'h2);
		wr(OFS_XINV, 32'h0);
		wr(OFS_WAKE, 32'(5) << B_SEL);
		cyc(3);
		chk(32'({wakeLevel, crystalPdEnable}), 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			wr(OFS_TWSEL, 32'(k) << B_TW_SDA);
			chk(32'(lpBusDataPad), 32'(k[0] ? TW_SDA_PAD1 : TW_SDA_PAD0));
			chk(32'(lpBusClockPad), 32'(k[1] ? TW_SCL_PAD1 : TW_SCL_PAD0));
		end
		chk(32'(tristateFault), 32'h0);
		end_of_test();
	end
endmodule : lppcb_bank_test
`default_nettype wire
